// ===== logic/pmx_params.svh
// Constants for the port output select and debug entry block
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
`define PMX_SEL_W 4
`define PMX_SEL_EN_BIT 3
`define PMX_SEL_IDX_W 2
`define PMX_SEL_RESET 4'h0
`define PMX_NUM_ALT 4
`endif

// ===== logic/pmx_pkg.sv
// Types for the port output select and debug entry block
package pmx_pkg;
  typedef logic [3:0] pmx_sel_type;
  typedef enum logic [1:0] {
    PMX_ST_RESET = 2'b00,
    PMX_ST_DEBUG_ARMED = 2'b01,
    PMX_ST_DEBUG_RUN = 2'b10,
    PMX_ST_NORMAL = 2'b11
  } pmx_dbg_state_type;
endpackage : pmx_pkg

// ===== logic/pmx_pin_mux.sv
// One pin output selector
`include "pmx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmx_pin_mux #(
  parameter int NUM_ALT = `PMX_NUM_ALT
) (
  input wire logic [`PMX_SEL_W-1:0] output_select_field,
  input wire logic [NUM_ALT-1:0] alt_outputs,
  input wire logic [NUM_ALT-1:0] alt_enables,
  input wire logic hardware_owned_en,
  input wire logic hardware_owned_output,
  output logic pin_out,
  output logic pin_oe
);
  logic [`PMX_SEL_IDX_W-1:0] idx;
  assign idx = output_select_field[`PMX_SEL_IDX_W-1:0];
  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    if (hardware_owned_en) begin
      pin_out = hardware_owned_output;
      pin_oe = 1'b1;
    end else if (output_select_field[`PMX_SEL_EN_BIT]) begin
      pin_out = alt_outputs[idx];
      pin_oe = alt_enables[idx];
    end
  end
endmodule : pmx_pin_mux
`default_nettype wire

// ===== logic/pmx_top.sv
// Port output select and debug entry top level
`include "pmx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmx_top #(
  parameter int NUM_PINS = 4,
  parameter int NUM_ALT = `PMX_NUM_ALT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NUM_PINS*`PMX_SEL_W-1:0] port_io_control_reg,
  input wire logic [NUM_PINS*NUM_ALT-1:0] alt_outputs,
  input wire logic [NUM_PINS-1:0] hardware_owned_en,
  input wire logic [NUM_PINS-1:0] hardware_owned_output,
  input wire logic power_on_reset_pin,
  input wire logic test_reset_pin,
  input wire logic factory_test_enable_pin,
  input wire logic jtag_pos_c_sel,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic debug_enable,
  output logic debug_reset,
  output logic factory_test_mode,
  output logic tdi_pull_up_en
);
  logic [2:0] por_s_r;
  logic [1:0] trst_s_r;
  logic [1:0] tm_s_r;
  logic [NUM_PINS-1:0] mux_out;
  logic [NUM_PINS-1:0] mux_oe;
  logic [NUM_PINS*`PMX_SEL_W-1:0] sel_r;
  pmx_pkg::pmx_dbg_state_type state_r;
  logic por_rise;
  logic por_low;
  logic trst_low;
  logic dbg_latched;
  logic dbg_running;

  // Power reset pin: two stages, third for the edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      por_s_r <= 3'h0;
    end else begin
      por_s_r <= {por_s_r[1:0], power_on_reset_pin};
    end
  end

  // Test reset idles low, like its pull-down
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trst_s_r <= 2'h0;
    end else begin
      trst_s_r <= {trst_s_r[0], test_reset_pin};
    end
  end

  // Factory pin idles high, so no false test entry
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tm_s_r <= 2'h3;
    end else begin
      tm_s_r <= {tm_s_r[0], factory_test_enable_pin};
    end
  end

  // Edge taken one stage past the synchroniser
  assign por_rise = por_s_r[1] & ~por_s_r[2];
  assign por_low = ~por_s_r[1];
  assign trst_low = ~trst_s_r[1];
  assign dbg_latched = (state_r == pmx_pkg::PMX_ST_DEBUG_ARMED) || (state_r == pmx_pkg::PMX_ST_DEBUG_RUN);
  assign dbg_running = (state_r == pmx_pkg::PMX_ST_DEBUG_RUN);

  // select fields reset to input code
  // Held while power reset is low, so only hardware owned pins drive early
  always_ff @(posedge ref_clk) begin
    if (!rst_n || por_low) begin
      sel_r <= {NUM_PINS{`PMX_SEL_RESET}};
    end else begin
      sel_r <= port_io_control_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      pmx_pin_mux #(.NUM_ALT(NUM_ALT)) u_mux (
        .output_select_field(sel_r[g*`PMX_SEL_W +: `PMX_SEL_W]),
        .alt_outputs(alt_outputs[g*NUM_ALT +: NUM_ALT]),
        .alt_enables({NUM_ALT{1'b1}}),
        .hardware_owned_en(hardware_owned_en[g]),
        .hardware_owned_output(hardware_owned_output[g]),
        .pin_out(mux_out[g]),
        .pin_oe(mux_oe[g])
      );
    end
  endgenerate

  // Pin value flop between mux and pad
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_out <= '0;
    end else begin
      pin_out <= mux_out;
    end
  end

  // Enable flop keeps pads quiet in reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= mux_oe;
    end
  end

  // latch test reset at power reset rise
  always_ff @(posedge ref_clk) begin
    if (!rst_n || por_low) begin
      state_r <= pmx_pkg::PMX_ST_RESET;
    end else begin
      unique case (state_r)
        pmx_pkg::PMX_ST_RESET: begin
          if (por_rise) begin
            if (trst_s_r[1]) begin
              state_r <= pmx_pkg::PMX_ST_DEBUG_ARMED;
            end else begin
              state_r <= pmx_pkg::PMX_ST_NORMAL;
            end
          end
        end
        pmx_pkg::PMX_ST_DEBUG_ARMED: begin
          if (trst_low) begin
            state_r <= pmx_pkg::PMX_ST_DEBUG_RUN;
          end
        end
        // Left only by rst_n or the next power reset
        pmx_pkg::PMX_ST_DEBUG_RUN: begin
          state_r <= pmx_pkg::PMX_ST_DEBUG_RUN;
        end
        pmx_pkg::PMX_ST_NORMAL: begin
          state_r <= pmx_pkg::PMX_ST_NORMAL;
        end
      endcase
    end
  end

  // Enable follows the latched strap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      debug_enable <= 1'b0;
    end else begin
      debug_enable <= dbg_latched;
    end
  end

  // Held high until the low pulse, then follows the inverted pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      debug_reset <= 1'b1;
    end else begin
      debug_reset <= !dbg_running || trst_low;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      factory_test_mode <= 1'b0;
    end else begin
      factory_test_mode <= ~tm_s_r[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tdi_pull_up_en <= 1'b0;
    end else begin
      tdi_pull_up_en <= jtag_pos_c_sel;
    end
  end
endmodule : pmx_top
`default_nettype wire

// ===== sim/pmx_top_properties.sv
// Port select and debug entry checker
`timescale 1ns/1ps
`default_nettype none
module pmx_top_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] port_io_control_reg,
  input wire logic [15:0] alt_outputs,
  input wire logic [3:0] hardware_owned_en,
  input wire logic [3:0] hardware_owned_output,
  input wire logic power_on_reset_pin,
  input wire logic test_reset_pin,
  input wire logic jtag_pos_c_sel,
  input wire logic factory_test_enable_pin,
  input wire logic factory_test_mode,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic debug_enable,
  input wire logic tdi_pull_up_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_ALT: assert property (port_io_control_reg[3] ##1 !hardware_owned_en[0] |=> pin_oe[0] &&
    pin_out[0] == alt_outputs[$past(port_io_control_reg[1:0], 2)]) else $error("alt route");
  AST_HW: assert property (hardware_owned_en[0] |=> pin_oe[0] &&
    pin_out[0] == $past(hardware_owned_output[0])) else $error("hw out");
  AST_DBG: assert property ($rose(power_on_reset_pin) ##1 $stable(test_reset_pin) [*3] |->
    ##4 debug_enable == $past(test_reset_pin, 7)) else $error("dbg latch");
  AST_PULL: assert property (jtag_pos_c_sel [*2] |-> tdi_pull_up_en) else $error("pull-up");
  AST_OFF: assert property (!port_io_control_reg[3] ##1 !hardware_owned_en[0] |=> !pin_oe[0]) else $error("oe");
  AST_FTM: assert property (factory_test_mode == !$past(factory_test_enable_pin, 3)) else $error("ftm");
endmodule : pmx_top_properties
bind pmx_top pmx_top_properties u_props (.*);
`default_nettype wire

// ===== sim/pmx_host.sv
// Debug host and board pin model
`timescale 1ns/1ps
`default_nettype none
module pmx_host (
  input wire logic dbg_req,
  input wire logic ftm_req,
  output logic test_reset_pin,
  output logic factory_test_enable_pin
);
  assign test_reset_pin = dbg_req;
  assign factory_test_enable_pin = ~ftm_req;
endmodule : pmx_host
`default_nettype wire

// ===== sim/port_output_select_and_debug_entry_bench.sv
// Port select and debug entry bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; $display("CHECK FAILED %s %h %h", n, e, s); end end
module port_output_select_and_debug_entry_bench;
  logic ref_clk = 1'h0, rst_n = 1'h0, power_on_reset_pin = 1'h0, jtag_pos_c_sel = 1'h0, dbg_req = 1'h0, ftm_req = 1'h0;
  logic [15:0] port_io_control_reg = 16'h0, alt_outputs = 16'h4b1e;
  logic [3:0] hardware_owned_en = 4'h0, hardware_owned_output = 4'h0, pin_out, pin_oe;
  logic test_reset_pin, factory_test_enable_pin, debug_enable, debug_reset, factory_test_mode, tdi_pull_up_en;
  int err_total = 0, n_compared = 0, cyc = 0;
  always #20 ref_clk = ~ref_clk;
  pmx_top u_pmx_top (.*);
  pmx_host u_pmx_host (.*);
  task automatic finish_test;
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) if (++cyc == 400) begin
    err_total++;
    finish_test;
  end
  task automatic go(int n);
    repeat (n) @(negedge ref_clk);
  endtask : go
  task automatic t_codes;
    for (int c = 0; c < 16; c++) begin
      port_io_control_reg = {4{c[3:0]}};
      go(3);
      for (int g = 0; g < 4; g++) begin
        `CHK("oe", c[3], pin_oe[g])
        `CHK("out", c[3] & alt_outputs[g*4+c[1:0]], pin_out[g])
      end
    end
  endtask : t_codes
  task automatic t_dbg(logic b);
    power_on_reset_pin = 1'h0;
    port_io_control_reg = 16'h0;
    hardware_owned_en = 4'h5;
    hardware_owned_output = {4{b}};
    dbg_req = b;
    go(4);
    `CHK("hw_oe", 4'h5, pin_oe)
    `CHK("hw_out", 4'h5 & {4{b}}, pin_out)
    power_on_reset_pin = 1'h1;
    go(9);
    `CHK("dbg", b, debug_enable)
    `CHK("dbg_rst", 1'h1, debug_reset)
    dbg_req = 1'h0;
    jtag_pos_c_sel = b;
    go(4);
    `CHK("dbg_hold", b, debug_enable)
    `CHK("pull", b, tdi_pull_up_en)
    `CHK("ftm", 1'h0, factory_test_mode)
    dbg_req = b;
    go(4);
    `CHK("dbg_free", ~b, debug_reset)
    `CHK("dbg_keep", b, debug_enable)
  endtask : t_dbg
  task automatic t_ftm;
    ftm_req = 1'h1;
    go(4);
    `CHK("ftm_on", 1'h1, factory_test_mode)
    ftm_req = 1'h0;
    go(4);
    `CHK("ftm_off", 1'h0, factory_test_mode)
  endtask : t_ftm
  initial begin
    go(3);
    rst_n = 1'h1;
    power_on_reset_pin = 1'h1;
    t_codes;
    t_dbg(1'h1);
    t_dbg(1'h0);
    t_ftm;
    finish_test;
  end
endmodule : port_output_select_and_debug_entry_bench
`default_nettype wire
